// ==== rtl/serial_shift_pkg.sv ====
// serial shift port: shared constants for both ends of the link
// assumes a single 40 MHz system clock on each end
package serial_shift_pkg;

  // wishbone slave geometry
  localparam int          WB_ADR_W         = 10;
  localparam int          WB_DAT_W         = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_IRQ_DISABLE  = 8'hC2;
  localparam logic [7:0]  IDX_SHIFT_DATA   = 8'hDD;
  localparam logic [7:0]  IDX_PORT_CTRL    = 8'hE0;
  localparam logic [7:0]  IDX_PORT_STATUS  = 8'hE1;

  // port_ctrl fields
  localparam int          CTRL_W           = 5;
  localparam int          CTRL_CLK_DRIVE   = 0;
  localparam int          CTRL_CLK_LEVEL   = 1;
  localparam int          CTRL_IN_PULL_LOW = 2;
  localparam int          CTRL_OUT_OD_MODE = 3;
  localparam int          CTRL_OUT_GPIO_LO = 4;
  localparam logic [4:0]  CTRL_RESET       = 5'h02;

  // port_status fields
  localparam int          STAT_COUNT_LSB   = 0;
  localparam int          STAT_TERMINAL    = 4;
  localparam int          STAT_IRQ_ENABLE  = 5;
  localparam int          STAT_IRQ_PENDING = 6;
  localparam int          STAT_IN_LEVEL    = 7;
  localparam int          STAT_CLK_LEVEL   = 8;

  // shift datapath
  localparam logic [3:0]  BYTE_BITS        = 4'h8;
  localparam logic [3:0]  ACK_BITS         = 4'h9;
  localparam logic [3:0]  LAST_EDGE_COUNT  = 4'h7;
  localparam logic [7:0]  SHIFT_RESET      = 8'h00;

  // timing of the peer's own shift clock
  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          LINK_PERIOD_NS   = 200;
  localparam int          HALF_RAW         = (LINK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  LINK_HALF_CYCLES = 8'((HALF_RAW < 1) ? 1 : HALF_RAW);

endpackage

// ==== rtl/serial_shift_link_if.sv ====
// serial shift link: three open-drain lines between port and peer
// the port gives a drive value and an active-low enable per line; the peer drives only the clock and in lines
`timescale 1ns/10ps
`default_nettype none
interface serial_shift_link_if;
  logic dev_clk_o;
  logic dev_clk_oe_n;
  logic dev_in_o;
  logic dev_in_oe_n;
  logic dev_out_o;
  logic dev_out_oe_n;
  logic peer_clk_o;
  logic peer_clk_oe_n;
  logic peer_data_o;
  logic peer_data_oe_n;
  logic clk_line;
  logic in_line;
  logic out_line;

  // wired-and with pull-up: any enabled driver of zero wins
  assign clk_line = !((!dev_clk_oe_n && !dev_clk_o) || (!peer_clk_oe_n && !peer_clk_o));
  assign in_line  = !((!dev_in_oe_n && !dev_in_o) || (!peer_data_oe_n && !peer_data_o));
  assign out_line = !(!dev_out_oe_n && !dev_out_o);

  modport device (
    output dev_clk_o, dev_clk_oe_n, dev_in_o, dev_in_oe_n, dev_out_o, dev_out_oe_n,
    input  clk_line, in_line
  );

  modport peer (
    output peer_clk_o, peer_clk_oe_n, peer_data_o, peer_data_oe_n,
    input  clk_line, in_line, out_line
  );
endinterface
`default_nettype wire

// ==== rtl/serial_shift_peer.sv ====
// serial shift peer: external clocking party of the shift link
// assumes its own 40 MHz clock; the port may stretch the clock line
`timescale 1ns/10ps
`default_nettype none
module serial_shift_peer #(
  parameter logic [7:0] HALF_CYCLES = serial_shift_pkg::LINK_HALF_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // user side
  input  wire logic        start_i,
  input  wire logic [7:0]  tx_i,
  input  wire logic        ack_clock_i,
  output logic      [7:0]  rx_o,
  output logic             ack_o,
  output logic             busy_o,
  output logic             done_o,
  // link side
  serial_shift_link_if.peer link
);
  import serial_shift_pkg::*;

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_HIGH = 2'b01,
    P_LOW  = 2'b11,
    P_FIN  = 2'b10
  } peer_state_t;

  typedef struct packed {
    logic [1:0]  clk_sync;
    logic [1:0]  in_sync;
    logic [1:0]  out_sync;
    peer_state_t state;
    logic [7:0]  tmr;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic [7:0]  rx;
    logic        nine;
    logic        ack;
    logic        busy;
    logic        done;
    logic        clk_oe_n;
    logic        data_oe_n;
  } peer_reg_t;

  peer_reg_t s;
  peer_reg_t next_s;
  logic [3:0] bit_next;
  logic [3:0] bit_total;

  always_comb begin
    next_s    = s;
    bit_next  = 4'(s.bitn + 4'h1);
    bit_total = s.nine ? ACK_BITS : BYTE_BITS;
    next_s.clk_sync = {s.clk_sync[0], link.clk_line};
    next_s.in_sync  = {s.in_sync[0], link.in_line};
    next_s.out_sync = {s.out_sync[0], link.out_line};
    next_s.done     = 1'b0;
    case (s.state)
      P_IDLE: begin
        if (start_i) begin
          next_s.shreg     = tx_i;
          next_s.nine      = ack_clock_i;
          next_s.bitn      = 4'h0;
          next_s.tmr       = 8'h00;
          next_s.ack       = 1'b0;
          next_s.busy      = 1'b1;
          next_s.data_oe_n = tx_i[7];
          next_s.state     = P_HIGH;
        end
      end
      P_HIGH: begin
        // the port may hold the line low; time only a released high
        if (s.clk_sync[1]) begin
          next_s.tmr = 8'(s.tmr + 8'h01);
          if (s.tmr >= 8'(HALF_CYCLES - 8'h01)) begin
            next_s.tmr = 8'h00;
            if (s.bitn < BYTE_BITS) begin
              next_s.rx = {s.rx[6:0], s.out_sync[1]};
            end else begin
              next_s.ack = !s.in_sync[1];
            end
            next_s.clk_oe_n = 1'b0;
            next_s.state    = P_LOW;
          end
        end
      end
      P_LOW: begin
        next_s.tmr = 8'(s.tmr + 8'h01);
        if (s.tmr >= 8'(HALF_CYCLES - 8'h01)) begin
          next_s.tmr      = 8'h00;
          next_s.bitn     = bit_next;
          next_s.clk_oe_n = 1'b1;
          next_s.shreg    = {s.shreg[6:0], 1'b0};
          if (bit_next == bit_total) begin
            next_s.data_oe_n = 1'b1;
            next_s.state     = P_FIN;
          end else begin
            // data changes at the rising edge, far from the sampling fall
            next_s.data_oe_n = (bit_next == BYTE_BITS) ? 1'b1 : s.shreg[6];
            next_s.state     = P_HIGH;
          end
        end
      end
      P_FIN: begin
        next_s.busy  = 1'b0;
        next_s.done  = 1'b1;
        next_s.state = P_IDLE;
      end
      default: begin
        next_s.state = P_IDLE;
      end
    endcase
    if (rst_i) begin
      next_s           = '0;
      next_s.state     = P_IDLE;
      next_s.clk_oe_n  = 1'b1;
      next_s.data_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign rx_o                = s.rx;
  assign ack_o               = s.ack;
  assign busy_o              = s.busy;
  assign done_o              = s.done;
  assign link.peer_clk_o     = 1'b0;
  assign link.peer_clk_oe_n  = s.clk_oe_n;
  assign link.peer_data_o    = 1'b0;
  assign link.peer_data_oe_n = s.data_oe_n;

endmodule
`default_nettype wire

// ==== rtl/serial_shift_port.sv ====
// serial shift port: 8-bit shift register, 4-bit edge counter, wishbone regs
// assumes classic wishbone master on clk_i; link lines resolved by interface
`timescale 1ns/10ps
`default_nettype none

module serial_shift_port (
  // clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // wishbone slave
  input  wire logic                                cyc_i,
  input  wire logic                                stb_i,
  input  wire logic                                we_i,
  input  wire logic [serial_shift_pkg::WB_ADR_W-1:0] adr_i,
  input  wire logic [3:0]                          sel_i,
  input  wire logic [serial_shift_pkg::WB_DAT_W-1:0] dat_i,
  output logic      [serial_shift_pkg::WB_DAT_W-1:0] dat_o,
  output logic                                     ack_o,
  // interrupt request, active low
  output logic                                     irq_n_o,
  // link side
  serial_shift_link_if.device                      link
);
  import serial_shift_pkg::*;

  typedef struct packed {
    logic [1:0]        clk_sync;
    logic [1:0]        in_sync;
    logic              clk_prev;
    logic [7:0]        shreg;
    logic [3:0]        cnt;
    logic              irq_en;
    logic              irq_n;
    logic [CTRL_W-1:0] ctrl;
    logic              ack;
    logic [WB_DAT_W-1:0] rdat;
    logic              clk_o;
    logic              clk_oe_n;
    logic              in_oe_n;
    logic              out_oe_n;
  } port_reg_t;

  port_reg_t s;
  port_reg_t next_s;

  logic       req;
  logic       wr;
  logic [7:0] idx;
  logic       fall;
  logic       counter_terminal_output;

  always_comb begin
    next_s = s;
    req    = cyc_i && stb_i && !s.ack;
    wr     = req && we_i;
    idx    = adr_i[9:2];

    // pin levels pass two flops before any logic looks at them
    next_s.clk_sync = {s.clk_sync[0], link.clk_line};
    next_s.in_sync  = {s.in_sync[0], link.in_line};
    next_s.clk_prev = s.clk_sync[1];
    fall            = s.clk_prev && !s.clk_sync[1];

    counter_terminal_output = !s.cnt[3];

    if (wr && idx == IDX_IRQ_DISABLE) begin
      next_s.irq_en = 1'b0;
      next_s.irq_n  = 1'b1;
    end

    if (fall && counter_terminal_output) begin
      next_s.shreg = {s.shreg[6:0], s.in_sync[1]};
      next_s.cnt   = 4'(s.cnt + 4'h1);
      if (s.cnt == LAST_EDGE_COUNT && s.irq_en) begin
        next_s.irq_n = 1'b0;
      end
    end

    // a data write restarts the byte, so it overrides a coincident edge
    if (wr && sel_i[0] && idx == IDX_SHIFT_DATA) begin
      next_s.shreg = dat_i[7:0];
      next_s.cnt   = 4'h0;
      next_s.irq_en = 1'b1;
      next_s.irq_n  = 1'b1;
    end

    if (wr && sel_i[0] && idx == IDX_PORT_CTRL) begin
      next_s.ctrl = dat_i[CTRL_W-1:0];
    end

    // single-cycle answer, ack drops the cycle after
    next_s.ack  = req;
    next_s.rdat = '0;
    if (req && !we_i) begin
      case (idx)
        IDX_SHIFT_DATA: begin
          next_s.rdat[7:0] = s.shreg;
        end
        IDX_PORT_CTRL: begin
          next_s.rdat[CTRL_W-1:0] = s.ctrl;
        end
        IDX_PORT_STATUS: begin
          next_s.rdat[STAT_COUNT_LSB +: 4] = s.cnt;
          next_s.rdat[STAT_TERMINAL]       = counter_terminal_output;
          next_s.rdat[STAT_IRQ_ENABLE]     = s.irq_en;
          next_s.rdat[STAT_IRQ_PENDING]    = !s.irq_n;
          next_s.rdat[STAT_IN_LEVEL]       = s.in_sync[1];
          next_s.rdat[STAT_CLK_LEVEL]      = s.clk_sync[1];
        end
        default: begin
          next_s.rdat = '0;
        end
      endcase
    end

    next_s.clk_oe_n = !next_s.ctrl[CTRL_CLK_DRIVE];
    next_s.clk_o    = next_s.ctrl[CTRL_CLK_LEVEL];
    next_s.in_oe_n  = !next_s.ctrl[CTRL_IN_PULL_LOW];
    if (next_s.ctrl[CTRL_OUT_OD_MODE]) begin
      next_s.out_oe_n = next_s.shreg[7];
    end else begin
      next_s.out_oe_n = !next_s.ctrl[CTRL_OUT_GPIO_LO];
    end

    if (rst_i) begin
      next_s          = '0;
      next_s.shreg    = SHIFT_RESET;
      next_s.irq_en   = 1'b0;
      next_s.irq_n    = 1'b1;
      next_s.ctrl     = CTRL_RESET;
      next_s.clk_o    = CTRL_RESET[CTRL_CLK_LEVEL];
      next_s.clk_oe_n = 1'b1;
      next_s.in_oe_n  = 1'b1;
      next_s.out_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign dat_o             = s.rdat;
  assign ack_o             = s.ack;
  assign irq_n_o           = s.irq_n;
  assign link.dev_clk_o    = s.clk_o;
  assign link.dev_clk_oe_n = s.clk_oe_n;
  // only ever pulls low; on the out line in open-drain mode the enable carries the bit
  assign link.dev_in_o     = 1'b0;
  assign link.dev_in_oe_n  = s.in_oe_n;
  assign link.dev_out_o    = 1'b0;
  assign link.dev_out_oe_n = s.out_oe_n;

endmodule
`default_nettype wire

// ==== verif/serial_shift_port_props.sv ====
// checker: open-drain values and phase timing of the shift link
// assumes instantiation beside the link interface on the port clock
`timescale 1ns/10ps
`default_nettype none
module serial_shift_port_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link lines
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe_n,
  input wire logic dev_in_o,
  input wire logic dev_in_oe_n,
  input wire logic dev_out_o,
  input wire logic dev_out_oe_n,
  input wire logic peer_clk_o,
  input wire logic peer_clk_oe_n,
  input wire logic peer_data_o,
  input wire logic peer_data_oe_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_low;
    (!peer_clk_oe_n) [*3];
  endsequence
  sequence s_high;
    peer_clk_oe_n [*3];
  endsequence
  property p_in_val;
    dev_in_o == 1'b0;
  endproperty
  a_in_val: assert property (p_in_val) else $error("in line drive not zero");
  property p_out_val;
    dev_out_o == 1'b0;
  endproperty
  a_out_val: assert property (p_out_val) else $error("out line drive not zero");
  property p_peer_val;
    !peer_clk_o && !peer_data_o;
  endproperty
  a_peer_val: assert property (p_peer_val) else $error("peer drive not zero");
  property p_dev_rel;
    $fell(rst_i) |-> dev_clk_o && dev_clk_oe_n && dev_in_oe_n && dev_out_oe_n;
  endproperty
  a_dev_rel: assert property (p_dev_rel) else $error("port lines held after reset");
  property p_peer_rel;
    $fell(rst_i) |-> peer_clk_oe_n && peer_data_oe_n;
  endproperty
  a_peer_rel: assert property (p_peer_rel) else $error("peer lines held after reset");
  // low phase long enough for the port synchroniser
  property p_low;
    $fell(peer_clk_oe_n) |-> s_low;
  endproperty
  a_low: assert property (p_low) else $error("clock low phase too short");
  property p_high;
    $rose(peer_clk_oe_n) |-> s_high;
  endproperty
  a_high: assert property (p_high) else $error("clock high phase too short");
  // data may only move while the clock is released
  property p_data;
    $changed(peer_data_oe_n) |-> peer_clk_oe_n;
  endproperty
  a_data: assert property (p_data) else $error("data moved in low phase");
endmodule
`default_nettype wire

// ==== verif/tb_serial_shift_port.sv ====
// testbench: port and peer joined by the link, port run over wishbone
// assumes one 40 MHz clock for both ends; the peer clocks the link until the last test, where the port toggles it
`timescale 1ns/10ps
`default_nettype none
module tb_serial_shift_port;
  import serial_shift_pkg::*;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc_i = 0;
  logic        stb_i = 0;
  logic        we_i = 0;
  logic [9:0]  adr_i = '0;
  logic [3:0]  sel_i = '0;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        irq_n_o;
  logic        start_i = 0;
  logic [7:0]  tx_i = '0;
  logic        ack_clock_i = 0;
  logic [7:0]  rx_o;
  logic        peer_ack;
  logic        done_o;
  int          seed = 64;
  int          failures = 0;
  int          check_count = 0;
  logic [31:0] r;
  logic [7:0]  d;
  logic [7:0]  t;
  always #12.5 clk_i = ~clk_i;
  serial_shift_link_if lnk ();
  serial_shift_port serial_shift_port_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_n_o(irq_n_o), .link(lnk));
  serial_shift_peer #(.HALF_CYCLES(LINK_HALF_CYCLES)) serial_shift_peer_i (.clk_i(clk_i), .rst_i(rst_i),
    .start_i(start_i), .tx_i(tx_i), .ack_clock_i(ack_clock_i), .rx_o(rx_o), .ack_o(peer_ack),
    .busy_o(), .done_o(done_o), .link(lnk));
  serial_shift_port_props serial_shift_port_props_i (.clk_i(clk_i), .rst_i(rst_i),
    .dev_clk_o(lnk.dev_clk_o), .dev_clk_oe_n(lnk.dev_clk_oe_n), .dev_in_o(lnk.dev_in_o),
    .dev_in_oe_n(lnk.dev_in_oe_n), .dev_out_o(lnk.dev_out_o), .dev_out_oe_n(lnk.dev_out_oe_n),
    .peer_clk_o(lnk.peer_clk_o), .peer_clk_oe_n(lnk.peer_clk_oe_n), .peer_data_o(lnk.peer_data_o),
    .peer_data_oe_n(lnk.peer_data_oe_n));
  // status fields that a test can predict
  function automatic logic [31:0] st_exp(input logic [3:0] cnt, input logic en, input logic pend);
    return {25'h0, pend, en, cnt < BYTE_BITS, cnt};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // disable writes go with no byte enable: they must act anyway
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] v, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= (idx == IDX_IRQ_DISABLE) ? 4'h0 : 4'hF;
    dat_i <= {24'($random(seed)), v};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    if (n >= 50) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] q;
    wb(1, idx, v, q);
  endtask
  // mid: rewrite the data register while bits are still arriving
  task automatic xfer(input logic [7:0] v, input logic ak, input logic mid);
    int n;
    @(posedge clk_i);
    start_i <= 1;
    tx_i <= v;
    ack_clock_i <= ak;
    @(posedge clk_i);
    start_i <= 0;
    if (mid) begin
      repeat (40) @(posedge clk_i);
      wr(IDX_SHIFT_DATA, 8'h3C);
    end
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      failures++;
      end_of_test();
    end
    repeat (6) @(posedge clk_i);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    repeat (4) @(posedge clk_i);
    wb(0, IDX_PORT_STATUS, 0, r);
    chk(r & 32'h7F, st_exp(0, 0, 0));
    // software sees both released lines high through the status poll
    chk({30'h0, r[8:7]}, 3);
    chk({31'h0, irq_n_o}, 1);
    wb(0, IDX_IRQ_DISABLE, 0, r);
    chk(r, 0);
    // unused port: no data write yet, so no request may appear
    chk({31'h0, irq_n_o}, 1);
    wb(0, 8'h10, 0, r);
    chk(r, 0);
    wr(IDX_PORT_CTRL, 8'h10);
    repeat (2) @(posedge clk_i);
    chk({31'h0, lnk.out_line}, 0);
    wr(IDX_SHIFT_DATA, 8'h80);
    wr(IDX_PORT_CTRL, 8'h08);
    repeat (2) @(posedge clk_i);
    chk({31'h0, lnk.out_line}, 1);
    for (int i = 0; i < 6; i++) begin
      d = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      t = (i < 2) ? ~d : 8'($random(seed));
      wr(IDX_SHIFT_DATA, d);
      chk({31'h0, irq_n_o}, 1);
      xfer(t, 0, 0);
      chk({24'h0, rx_o}, {24'h0, d});
      wb(0, IDX_SHIFT_DATA, 0, r);
      chk(r, {24'h0, t});
      chk({31'h0, irq_n_o}, 0);
      wb(0, IDX_PORT_STATUS, 0, r);
      chk(r & 32'h5F, st_exp(8, 0, 1));
    end
    // peer data and ack share the in line
    wr(IDX_PORT_CTRL, 8'h0C);
    xfer(8'h5A, 1, 0);
    chk({31'h0, peer_ack}, 1);
    wb(0, IDX_SHIFT_DATA, 0, r);
    chk(r, {24'h0, t});
    wr(IDX_PORT_CTRL, 8'h08);
    wr(IDX_IRQ_DISABLE, 8'($random(seed)));
    chk({31'h0, irq_n_o}, 1);
    wb(0, IDX_PORT_STATUS, 0, r);
    chk(r & 32'h7F, st_exp(8, 0, 0));
    wr(IDX_SHIFT_DATA, 8'h11);
    wr(IDX_IRQ_DISABLE, 8'h00);
    xfer(8'hC3, 0, 0);
    chk({31'h0, irq_n_o}, 1);
    wb(0, IDX_SHIFT_DATA, 0, r);
    chk(r, 32'hC3);
    wr(IDX_SHIFT_DATA, 8'h22);
    xfer(8'h96, 0, 1);
    chk({31'h0, irq_n_o}, 1);
    wb(0, IDX_PORT_STATUS, 0, r);
    chk({31'h0, r[3:0] < BYTE_BITS}, 1);
    // own clock by register toggles; the ninth fall must be ignored
    wr(IDX_SHIFT_DATA, 8'h00);
    repeat (9) begin
      // driving zero holds the clock low
      wr(IDX_PORT_CTRL, 8'h09);
      repeat (4) @(posedge clk_i);
      wr(IDX_PORT_CTRL, 8'h0B);
      repeat (4) @(posedge clk_i);
    end
    wb(0, IDX_SHIFT_DATA, 0, r);
    chk(r, 32'hFF);
    chk({31'h0, irq_n_o}, 0);
    wb(0, IDX_PORT_STATUS, 0, r);
    chk(r & 32'h5F, st_exp(8, 0, 1));
    wr(IDX_PORT_CTRL, 8'h02);
    end_of_test();
  end
endmodule
`default_nettype wire
